/* hw/alal_core.sv */
`timescale 1ns/1ns
`default_nettype none
`include "alal_params.svh"

module alal_core #(
    parameter int CONV_CYCLES =
        `ALAL_CONV_TIME_MS * (`ALAL_CLK_HZ / 1000)
) (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic [7:0] primary_sensor_code,
    input wire logic [7:0] second_sensor_code,
    input wire logic sink6_request,
    input wire logic any_sink_on,
    output logic sink6_drive_en,
    output logic second_sensor_active,
    output logic [1:0] brightness_level,
    output logic conv_done,
    output logic sensor1_change_irq,
    output logic sensor2_change_irq,
    output logic [1:0] office_flag,
    output logic [1:0] dark_flag
);

    localparam int CW = $clog2(CONV_CYCLES + 1);
    localparam logic [CW-1:0] CONV_LAST = CW'(CONV_CYCLES - 1);

    // ==========================================================
    // Register file
    logic [7:0] mode_reg;
    logic [7:0] cfg_reg;
    logic [7:0] scfg_reg [2];
    logic [7:0] otrip_reg;
    logic [7:0] ohys_reg;
    logic [7:0] dtrip_reg;
    logic [7:0] dhys_reg;
    logic [1:0] irq_reg;
    logic [1:0] irq_next;
    logic force_reg;
    logic force_next;
    logic [1:0] lvl_reg;
    logic [1:0] lvl_next;

    wire wr_mode = reg_wr && reg_addr == `ALAL_MODE_ADDR;
    wire wr_irq = reg_wr && reg_addr == `ALAL_IRQ_ADDR;
    wire wr_cfg = reg_wr && reg_addr == `ALAL_CFG_ADDR;
    wire wr_sa = reg_wr && reg_addr == `ALAL_SCFG_A_ADDR;
    wire wr_sb = reg_wr && reg_addr == `ALAL_SCFG_B_ADDR;
    wire wr_ot = reg_wr && reg_addr == `ALAL_OTRIP_ADDR;
    wire wr_oh = reg_wr && reg_addr == `ALAL_OHYS_ADDR;
    wire wr_dt = reg_wr && reg_addr == `ALAL_DTRIP_ADDR;
    wire wr_dh = reg_wr && reg_addr == `ALAL_DHYS_ADDR;

    wire bl_on = mode_reg[`ALAL_MODE_BL_ON];
    wire auto_level_enable = mode_reg[`ALAL_MODE_AUTO];
    wire second_sensor_select = cfg_reg[`ALAL_CFG_SEL2];
    wire sensor_channel_select = cfg_reg[`ALAL_CFG_SELAB];

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            mode_reg <= `ALAL_RST8;
            cfg_reg <= `ALAL_RST8;
            scfg_reg[0] <= `ALAL_RST8;
            scfg_reg[1] <= `ALAL_RST8;
            otrip_reg <= `ALAL_RST8;
            ohys_reg <= `ALAL_RST8;
            dtrip_reg <= `ALAL_RST8;
            dhys_reg <= `ALAL_RST8;
        end else if (ce) begin
            if (wr_mode) mode_reg <= reg_wdata;
            if (wr_cfg) cfg_reg <= reg_wdata;
            if (wr_sa) scfg_reg[0] <= reg_wdata;
            if (wr_sb) scfg_reg[1] <= reg_wdata;
            if (wr_ot) otrip_reg <= reg_wdata;
            if (wr_oh) ohys_reg <= reg_wdata;
            if (wr_dt) dtrip_reg <= reg_wdata;
            if (wr_dh) dhys_reg <= reg_wdata;
        end
    end

    // ==========================================================
    // Shared sixth pin
    assign sink6_drive_en = sink6_request && !second_sensor_select;
    assign second_sensor_active = second_sensor_select;

    // ==========================================================
    // Conversion sequencer
    // The single-shot request is refused outright while the backlight
    // runs or no sink is lit, so software sees it read back as zero.
    alal_pkg::alal_conv_state_t state_reg;
    alal_pkg::alal_conv_state_t state_next;
    logic [CW-1:0] cnt_reg;
    logic [CW-1:0] cnt_next;

    wire run_req = auto_level_enable || force_reg;
    wire conv_end = cnt_reg == CONV_LAST;
    wire force_ok = !bl_on && any_sink_on;

    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        conv_done = 1'b0;
        case (state_reg)
            alal_pkg::ALAL_IDLE: begin
                cnt_next = '0;
                if (run_req) state_next = alal_pkg::ALAL_CONV;
            end
            alal_pkg::ALAL_CONV: begin
                cnt_next = cnt_reg + 1'b1;
                if (!run_req) begin
                    state_next = alal_pkg::ALAL_IDLE;
                end else if (conv_end) begin
                    conv_done = ce;
                    cnt_next = '0;
                    if (!auto_level_enable) begin
                        state_next = alal_pkg::ALAL_IDLE;
                    end
                end
            end
            default: begin
                state_next = alal_pkg::ALAL_IDLE;
                cnt_next = '0;
            end
        endcase
    end

    assign force_next = wr_cfg ?
        (reg_wdata[`ALAL_CFG_FORCE] && force_ok) :
        (force_reg && !conv_done);

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            state_reg <= alal_pkg::ALAL_IDLE;
            cnt_reg <= '0;
            force_reg <= 1'b0;
        end else if (ce) begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            force_reg <= force_next;
        end
    end

    // ==========================================================
    // Trip comparators with hysteresis and filter
    // Index g: channel g/2, office when g is even, dark when odd.
    // The filter counts whole conversions, so a setting of n
    // demands 2**n agreeing results: 80 ms up to about 10 s.
    wire [3:0] flag_w;
    wire [3:0] flip_w;

    wire [8:0] office_sum = {1'b0, otrip_reg} + {1'b0, ohys_reg};
    wire [8:0] dark_sum = {1'b0, dtrip_reg} + {1'b0, dhys_reg};

    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : gen_cmp
            localparam int CH = g / 2;
            localparam bit DARK = (g % 2) == 1;
            logic flag_reg;
            logic [7:0] agree_reg;
            wire [7:0] code_raw = (CH == 0) ?
                primary_sensor_code : second_sensor_code;
            // Office codes beyond full scale clip, so an oversized
            // trip plus hysteresis can never be exceeded.
            wire [7:0] code = (!DARK && code_raw > `ALAL_OFFICE_FULL) ?
                `ALAL_OFFICE_FULL : code_raw;
            wire [7:0] trip = DARK ? dtrip_reg : otrip_reg;
            wire [8:0] limit = DARK ? dark_sum : office_sum;
            wire en = scfg_reg[CH][DARK ? `ALAL_SCFG_DEN :
                `ALAL_SCFG_OEN];
            wire [2:0] fsel = DARK ?
                scfg_reg[CH][`ALAL_SCFG_DFILT_LO +: `ALAL_FILT_W] :
                scfg_reg[CH][`ALAL_SCFG_OFILT_LO +: `ALAL_FILT_W];
            wire [7:0] need = 8'h01 << fsel;
            wire below = code < trip;
            wire above = {1'b0, code} > limit;
            wire want = en && (flag_reg ? !above : below);
            wire ch_done = conv_done &&
                (CH == 0 || second_sensor_active);
            wire differ = want != flag_reg;
            wire [7:0] agree_inc = agree_reg + 8'h01;
            assign flip_w[g] = ch_done && differ &&
                agree_inc >= need;
            assign flag_w[g] = flag_reg;

            always_ff @(posedge core_clk) begin
                if (!rstn) begin
                    flag_reg <= 1'b0;
                    agree_reg <= 8'h00;
                end else if (ce && ch_done) begin
                    if (flip_w[g]) begin
                        flag_reg <= want;
                        agree_reg <= 8'h00;
                    end else if (differ) begin
                        agree_reg <= agree_inc;
                    end else begin
                        agree_reg <= 8'h00;
                    end
                end
            end
        end
    endgenerate

    assign office_flag = {flag_w[2], flag_w[0]};
    assign dark_flag = {flag_w[3], flag_w[1]};

    // ==========================================================
    // Change flags: a new edge beats a clear in the same cycle.
    assign irq_next[0] = (irq_reg[0] && !(wr_irq && reg_wdata[0])) ||
        flip_w[0] || flip_w[1];
    assign irq_next[1] = (irq_reg[1] && !(wr_irq && reg_wdata[1])) ||
        flip_w[2] || flip_w[3];

    always_ff @(posedge core_clk) begin
        if (!rstn) irq_reg <= 2'b00;
        else if (ce) irq_reg <= irq_next;
    end

    assign sensor1_change_irq = irq_reg[0];
    assign sensor2_change_irq = irq_reg[1];

    // ==========================================================
    // Backlight level selection
    wire sel_ch = second_sensor_active && sensor_channel_select;
    wire sel_dark = dark_flag[sel_ch];
    wire sel_office = office_flag[sel_ch];
    wire [1:0] auto_lvl = sel_dark ? alal_pkg::ALAL_DARK :
        sel_office ? alal_pkg::ALAL_OFFICE :
        alal_pkg::ALAL_DAYLIGHT;

    assign lvl_next = auto_level_enable ? auto_lvl :
        wr_cfg ? reg_wdata[`ALAL_CFG_LVL_HI:`ALAL_CFG_LVL_LO] :
        lvl_reg;

    always_ff @(posedge core_clk) begin
        if (!rstn) lvl_reg <= alal_pkg::ALAL_DAYLIGHT;
        else if (ce) lvl_reg <= lvl_next;
    end

    assign brightness_level = lvl_reg;

    // ==========================================================
    // Read path
    wire [7:0] cfg_view = {cfg_reg[7:5], lvl_reg,
        cfg_reg[`ALAL_CFG_SELAB:`ALAL_CFG_SEL2], force_reg};
    wire [7:0] status_view = {4'h0, dark_flag, office_flag};
    wire [7:0] rd_mux =
        reg_addr == `ALAL_MODE_ADDR ? mode_reg :
        reg_addr == `ALAL_IRQ_ADDR ? {6'h00, irq_reg} :
        reg_addr == `ALAL_CFG_ADDR ? cfg_view :
        reg_addr == `ALAL_SCFG_A_ADDR ? scfg_reg[0] :
        reg_addr == `ALAL_SCFG_B_ADDR ? scfg_reg[1] :
        reg_addr == `ALAL_OTRIP_ADDR ? otrip_reg :
        reg_addr == `ALAL_OHYS_ADDR ? ohys_reg :
        reg_addr == `ALAL_DTRIP_ADDR ? dtrip_reg :
        reg_addr == `ALAL_DHYS_ADDR ? dhys_reg :
        reg_addr == `ALAL_STATUS_ADDR ? status_view : 8'h00;

    always_ff @(posedge core_clk) begin
        if (!rstn) reg_rdata <= 8'h00;
        else if (ce && reg_rd) reg_rdata <= rd_mux;
    end

    // ==========================================================
    // Checks
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rstn);

    sequence auto_held;
        auto_level_enable && ce ##1 auto_level_enable;
    endsequence

    pin_share_a: assert property (
        sink6_drive_en |-> !second_sensor_active)
        else $error("sixth pin sinks while used as sensor input");

    dark_wins_a: assert property (
        (sel_dark ##0 auto_held) |-> brightness_level == 2'b10)
        else $error("dark flag did not select dark level");

    day_level_a: assert property (
        (!sel_dark && !sel_office ##0 auto_held)
        |-> brightness_level == 2'b00)
        else $error("clear flags did not select daylight");

    flags_hold_a: assert property (
        !conv_done |=> $stable(flag_w))
        else $error("flag moved without a completed conversion");

    office_set_a: assert property (
        $rose(office_flag[0]) |->
        $past(primary_sensor_code) < $past(otrip_reg))
        else $error("office flag set without code below trip");

    dark_set_a: assert property (
        $rose(dark_flag[0]) |->
        $past(primary_sensor_code) < $past(dtrip_reg))
        else $error("dark flag set without code below trip");

    office_stuck_a: assert property (
        $fell(office_flag[0]) |-> $past(office_sum) <= 9'h0FA ||
        !$past(scfg_reg[0][`ALAL_SCFG_OEN]))
        else $error("office flag cleared past full scale");

    edge_irq_a: assert property (
        ce && (flip_w[0] || flip_w[1]) |=> sensor1_change_irq)
        else $error("flag edge did not raise change flag");

    force_done_a: assert property (
        force_reg && conv_done && !wr_cfg |=> !force_reg)
        else $error("force read not cleared after measurement");

endmodule

`default_nettype wire

/* common/alal_params.svh */
`ifndef ALAL_PARAMS_SVH
`define ALAL_PARAMS_SVH

// ==========================================================
// Register offsets
`define ALAL_MODE_ADDR 8'h01
`define ALAL_IRQ_ADDR 8'h02
`define ALAL_CFG_ADDR 8'h04
`define ALAL_SCFG_A_ADDR 8'h1B
`define ALAL_SCFG_B_ADDR 8'h1C
`define ALAL_OTRIP_ADDR 8'h1D
`define ALAL_OHYS_ADDR 8'h1E
`define ALAL_DTRIP_ADDR 8'h1F
`define ALAL_DHYS_ADDR 8'h20
`define ALAL_STATUS_ADDR 8'h21

// ==========================================================
// Field positions
`define ALAL_MODE_BL_ON 0
`define ALAL_MODE_AUTO 1
`define ALAL_CFG_FORCE 0
`define ALAL_CFG_SEL2 1
`define ALAL_CFG_SELAB 2
`define ALAL_CFG_LVL_LO 3
`define ALAL_CFG_LVL_HI 4
`define ALAL_SCFG_OEN 0
`define ALAL_SCFG_DEN 1
`define ALAL_SCFG_OFILT_LO 2
`define ALAL_SCFG_DFILT_LO 5
`define ALAL_FILT_W 3

// ==========================================================
// Values and timing
`define ALAL_RST8 8'h00
`define ALAL_OFFICE_FULL 8'hFA
`define ALAL_CONV_TIME_MS 80
`define ALAL_CLK_HZ 25000000

`endif

/* common/alal_pkg.sv */
`default_nettype none

package alal_pkg;

    typedef enum logic [1:0] {
        ALAL_IDLE = 2'b01,
        ALAL_CONV = 2'b10
    } alal_conv_state_t;

    typedef enum logic [1:0] {
        ALAL_DAYLIGHT = 2'b00,
        ALAL_OFFICE = 2'b01,
        ALAL_DARK = 2'b10
    } alal_level_t;

endpackage

`default_nettype wire

/* testbench/alal_light_model.sv */
`timescale 1ns/1ns
`default_nettype none

// ==========================================================
// Phototransistor pair seen through the converters
module alal_light_model (
    input wire logic core_clk,
    input wire logic [7:0] light1,
    input wire logic [7:0] light2,
    output logic [7:0] code1,
    output logic [7:0] code2
);
    // The codes trail the scene by one clock, as a sampled photocurrent
    // would, so a change can land in the same step as a conversion.
    always_ff @(posedge core_clk) begin
        code1 <= light1;
        code2 <= light2;
    end
endmodule

`default_nettype wire

/* testbench/tb_ambient_light_auto_level.sv */
`timescale 1ns/1ns
`default_nettype none
`include "alal_params.svh"

module tb_ambient_light_auto_level;
    localparam int CONV = 8;
    logic core_clk = 1'b0;
    logic rstn = 1'b0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] light1 = 8'hFF;
    logic [7:0] light2 = 8'hFF;
    logic sink6_request = 1'b0;
    logic any_sink_on = 1'b0;
    logic ce = 1'b1;
    logic [7:0] reg_rdata, code1, code2;
    logic sink6_drive_en, second_sensor_active, conv_done, irq1, irq2;
    logic [1:0] brightness_level, office_flag, dark_flag;
    int bad_count = 0;
    int check_count = 0;
    int n;

    always #20 core_clk = ~core_clk;

    alal_light_model light_u (
        .core_clk(core_clk), .light1(light1), .light2(light2),
        .code1(code1), .code2(code2)
    );

    alal_core #(.CONV_CYCLES(CONV)) dut_u (
        .core_clk(core_clk), .rstn(rstn), .ce(ce),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .primary_sensor_code(code1), .second_sensor_code(code2),
        .sink6_request(sink6_request), .any_sink_on(any_sink_on),
        .sink6_drive_en(sink6_drive_en),
        .second_sensor_active(second_sensor_active),
        .brightness_level(brightness_level), .conv_done(conv_done),
        .sensor1_change_irq(irq1), .sensor2_change_irq(irq2),
        .office_flag(office_flag), .dark_flag(dark_flag)
    );

    // ==========================================================
    // Shared tasks
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
            bad_count++;
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge core_clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge core_clk);
        reg_wr = 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(negedge core_clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge core_clk);
        reg_rd = 1'b0;
        chk(reg_rdata, exp);
    endtask

    // A scene change may miss the conversion in flight, so the caller
    // asks for two and trusts only the second.
    task automatic wait_conv(input int count);
        repeat (count) begin
            n = 0;
            while (conv_done !== 1'b1 && n < 4 * CONV) begin
                @(negedge core_clk);
                n++;
            end
            chk({7'h00, conv_done}, 8'h01);
            @(negedge core_clk);
        end
        repeat (2) @(negedge core_clk);
    endtask

    task automatic chk_state(input logic [1:0] ofl, input logic [1:0] dfl,
                             input logic [1:0] lvl);
        chk({6'h00, office_flag}, {6'h00, ofl});
        chk({6'h00, dark_flag}, {6'h00, dfl});
        chk({6'h00, brightness_level}, {6'h00, lvl});
    endtask

    task automatic end_sim;
        $display("Checks %0d, mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_reset;
        rd_chk(`ALAL_MODE_ADDR, 8'h00);
        rd_chk(`ALAL_CFG_ADDR, 8'h00);
        rd_chk(`ALAL_SCFG_A_ADDR, 8'h00);
        rd_chk(`ALAL_STATUS_ADDR, 8'h00);
        rd_chk(8'h30, 8'h00);
    endtask

    task automatic t_pin;
        sink6_request = 1'b1;
        @(negedge core_clk);
        chk({7'h00, sink6_drive_en}, 8'h01);
        wr(`ALAL_CFG_ADDR, 8'h02);
        chk({6'h00, sink6_drive_en, second_sensor_active}, 8'h01);
        wr(`ALAL_CFG_ADDR, 8'h00);
        chk({7'h00, sink6_drive_en}, 8'h01);
    endtask

    task automatic t_office;
        wr(`ALAL_OTRIP_ADDR, 8'h64);
        wr(`ALAL_OHYS_ADDR, 8'h0A);
        wr(`ALAL_SCFG_A_ADDR, 8'h01);
        wr(`ALAL_MODE_ADDR, 8'h02);
        light1 = 8'h5A;
        wait_conv(2);
        chk_state(2'b01, 2'b00, 2'b01);
        chk({7'h00, irq1}, 8'h01);
        light1 = 8'h6F;
        repeat (2) @(negedge core_clk);
        chk({6'h00, office_flag}, 8'h01);
        light1 = 8'h6E;
        wait_conv(2);
        chk({6'h00, office_flag}, 8'h01);
        light1 = 8'h6F;
        wait_conv(2);
        chk_state(2'b00, 2'b00, 2'b00);
        wait_conv(1);
        chk({6'h00, office_flag}, 8'h00);
        wr(`ALAL_IRQ_ADDR, 8'h01);
        chk({7'h00, irq1}, 8'h00);
    endtask

    task automatic t_dark;
        wr(`ALAL_DTRIP_ADDR, 8'h32);
        wr(`ALAL_DHYS_ADDR, 8'h05);
        wr(`ALAL_SCFG_A_ADDR, 8'h03);
        light1 = 8'h28;
        wait_conv(2);
        chk_state(2'b01, 2'b01, 2'b10);
        rd_chk(`ALAL_STATUS_ADDR, 8'h05);
        light1 = 8'h37;
        wait_conv(2);
        chk({6'h00, dark_flag}, 8'h01);
        light1 = 8'h38;
        wait_conv(2);
        chk_state(2'b01, 2'b00, 2'b01);
        wr(`ALAL_SCFG_A_ADDR, 8'h02);
        light1 = 8'h28;
        wait_conv(2);
        chk_state(2'b00, 2'b01, 2'b10);
    endtask

    task automatic t_full;
        wr(`ALAL_OTRIP_ADDR, 8'hC8);
        wr(`ALAL_OHYS_ADDR, 8'h3C);
        wr(`ALAL_SCFG_A_ADDR, 8'h01);
        light1 = 8'hBE;
        wait_conv(2);
        chk({6'h00, office_flag}, 8'h01);
        light1 = 8'hFF;
        wait_conv(3);
        chk({6'h00, office_flag}, 8'h01);
    endtask

    // Channel 1 drops its office flag in the same window, so both
    // change flags are expected up.
    task automatic t_chan2;
        wr(`ALAL_OTRIP_ADDR, 8'h64);
        wr(`ALAL_OHYS_ADDR, 8'h0A);
        wr(`ALAL_CFG_ADDR, 8'h02);
        wr(`ALAL_SCFG_B_ADDR, 8'h01);
        light2 = 8'h10;
        wait_conv(2);
        chk_state(2'b10, 2'b00, 2'b00);
        chk({6'h00, irq2, irq1}, 8'h03);
        wr(`ALAL_CFG_ADDR, 8'h06);
        repeat (2) @(negedge core_clk);
        chk({6'h00, brightness_level}, 8'h01);
    endtask

    // The second channel is deselected here, so its office flag holds.
    task automatic t_force;
        wr(`ALAL_MODE_ADDR, 8'h00);
        wr(`ALAL_CFG_ADDR, 8'h10);
        chk({6'h00, brightness_level}, 8'h02);
        light1 = 8'h10;
        any_sink_on = 1'b0;
        wr(`ALAL_CFG_ADDR, 8'h11);
        rd_chk(`ALAL_CFG_ADDR, 8'h10);
        any_sink_on = 1'b1;
        wr(`ALAL_MODE_ADDR, 8'h01);
        wr(`ALAL_CFG_ADDR, 8'h11);
        rd_chk(`ALAL_CFG_ADDR, 8'h10);
        wr(`ALAL_MODE_ADDR, 8'h00);
        wr(`ALAL_CFG_ADDR, 8'h11);
        n = 0;
        while (conv_done !== 1'b1 && n < 4 * CONV) begin
            @(negedge core_clk);
            n++;
        end
        chk({7'h00, n >= CONV - 1 && n <= CONV + 1}, 8'h01);
        repeat (3) @(negedge core_clk);
        chk({6'h00, office_flag}, 8'h03);
        rd_chk(`ALAL_CFG_ADDR, 8'h10);
    endtask

    // A filter setting of 2 wants four agreeing conversions, so two
    // leave the flag alone and five are sure to have moved it.
    task automatic t_filter;
        wr(`ALAL_SCFG_A_ADDR, 8'h09);
        wr(`ALAL_IRQ_ADDR, 8'h03);
        wr(`ALAL_MODE_ADDR, 8'h02);
        light1 = 8'h78;
        wait_conv(2);
        chk_state(2'b11, 2'b00, 2'b01);
        chk({6'h00, irq2, irq1}, 8'h00);
        wait_conv(3);
        chk_state(2'b10, 2'b00, 2'b00);
        chk({6'h00, irq2, irq1}, 8'h01);
    endtask

    // With the enable low nothing may move: no conversion ends and a
    // write is lost.
    task automatic t_freeze;
        ce = 1'b0;
        wr(`ALAL_OTRIP_ADDR, 8'h55);
        n = 0;
        repeat (2 * CONV) begin
            @(negedge core_clk);
            if (conv_done !== 1'b0) n++;
        end
        chk(n[7:0], 8'h00);
        chk({6'h00, office_flag}, 8'h02);
        ce = 1'b1;
        rd_chk(`ALAL_OTRIP_ADDR, 8'h64);
        wait_conv(1);
    endtask

    // ==========================================================
    // Main sequence and watchdog
    initial begin
        repeat (10) @(negedge core_clk);
        rstn = 1'b1;
        t_reset();
        t_pin();
        t_office();
        t_dark();
        t_full();
        t_chan2();
        t_force();
        t_filter();
        t_freeze();
        end_sim();
    end

    // The whole run needs well under 3000 cycles; this is ten times that.
    initial begin
        #1200000;
        bad_count++;
        end_sim();
    end
endmodule

`default_nettype wire
